// >>> rtl/quad_decoder_pkg.sv
// Operation
// - reading a counter register copies every counter into its hold register
// - counters and holds take writes; a later counter read overwrites the holds
// - position loads from upper and lower init halves; software programs both first
// - writing one to control bit 11 loads position; it reads zero
// - home event sets control bit 15; writing one clears it
// - control bit 14 enables the home interrupt request
// - control bit 13 lets the home edge load the position counter
// - control bit 12 picks the home edge: one falling, zero rising
// - control bit 10 inverts the decoded count direction
// - control bit 9 counts phase A rises, direction from phase B and invert bit
// - index event sets control bit 8; writing one clears it
// - control bit 7 enables the index interrupt request
// - control bit 6 lets the index edge load the position counter
// - control bit 5 picks the index edge: one falling, zero rising
// - watchdog time-out sets control bit 4; writing one clears it
// - control bit 3 enables the time-out interrupt request
// - control bit 2 enables the motion watchdog on phases A and B
// - control bits 1..0 route raw, filtered or split phases to timer channels
// - filter interval counter restarts at the interval and takes a new sample
// - interval zero bypasses the filter on all four inputs
// - sample period is the eight-bit interval plus one clocks
// - filter latency is (interval+1) times two samples plus two up to (interval+1) times three samples plus one clocks
// - watchdog times out after the 16-bit count plus one clocks and sets its flag
// - two successive count events in the same direction restart the watchdog timer
// - filter output changes only when most of the four samples agree
// - reading position snapshots all counters then clears the difference counter
package quad_decoder_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FILTER = 8'h04;
	localparam logic [7:0] OFS_TIMEOUT = 8'h08;
	localparam logic [7:0] OFS_DELTA = 8'h0c;
	localparam logic [7:0] OFS_DELTA_HOLD = 8'h10;
	localparam logic [7:0] OFS_REVS = 8'h14;
	localparam logic [7:0] OFS_REVS_HOLD = 8'h18;
	localparam logic [7:0] OFS_POS_UPPER = 8'h1c;
	localparam logic [7:0] OFS_POS_LOWER = 8'h20;
	localparam logic [7:0] OFS_HOLD_UPPER = 8'h24;
	localparam logic [7:0] OFS_HOLD_LOWER = 8'h28;
	localparam logic [7:0] OFS_INIT_UPPER = 8'h2c;
	localparam logic [7:0] OFS_INIT_LOWER = 8'h30;
	localparam logic [7:0] OFS_MONITOR = 8'h34;

	// ----------------------------------------------------------------
	// control register layout and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RW_MASK = 16'h76ef;
	localparam logic [15:0] CTRL_W1C_MASK = 16'h8110;
	localparam int SOFT_INIT_BIT = 11;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] TIMEOUT_RESET = 16'hffff;
	localparam int FILTER_SAMPLES = 4;
	localparam int FILTER_MAJORITY = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ROUTE_RAW = 2'h0,
		ROUTE_FILTERED = 2'h1,
		ROUTE_SPLIT = 2'h2,
		ROUTE_RESERVED = 2'h3
	} route_mode_e;

	typedef struct packed {
		logic home_event_flag;
		logic home_irq_enable;
		logic home_init_enable;
		logic home_falling_select;
		logic soft_init_trigger;
		logic reverse_count;
		logic single_phase_count;
		logic idx_event_flag;
		logic idx_irq_enable;
		logic idx_init_enable;
		logic idx_falling_select;
		logic timeout_event_flag;
		logic timeout_irq_enable;
		logic motion_monitor_enable;
		route_mode_e route_mode;
	} decoder_control_s;

	typedef struct packed {
		logic quad_input_a;
		logic quad_input_b;
		logic index;
		logic home;
	} encoder_pins_s;

endpackage

// >>> rtl/quad_decoder_control.sv
`timescale 1ns/10ps
module quad_decoder_control import quad_decoder_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// encoder pins
	input wire encoder_pins_s encoder_in,
	// timer capture channels and interrupt
	output logic [3:0] timer_capture_out,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr);
		unique case (addr)
			OFS_CTRL, OFS_FILTER, OFS_TIMEOUT, OFS_DELTA, OFS_DELTA_HOLD,
			OFS_REVS, OFS_REVS_HOLD, OFS_POS_UPPER, OFS_POS_LOWER,
			OFS_HOLD_UPPER, OFS_HOLD_LOWER, OFS_INIT_UPPER, OFS_INIT_LOWER,
			OFS_MONITOR: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction

	function automatic logic edge_sel(input logic prev, input logic cur, input logic fall);
		edge_sel = fall ? (prev & ~cur) : (~prev & cur);
	endfunction

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [15:0] w_data;
	logic [15:0] w_mask;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_word;

	assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
	assign s_axi_wready_out = ~w_held & ~s_axi_bvalid_out;
	assign s_axi_arready_out = ~s_axi_rvalid_out;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid_out;
	assign rd_fire = s_axi_arvalid_in & s_axi_arready_out;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 16'h0000;
			w_mask <= 16'h0000;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in[15:0];
				w_mask <= {{8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= reg_hit(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	function automatic logic [15:0] merge(input logic [15:0] old);
		merge = (old & ~w_mask) | (w_data & w_mask);
	endfunction

	function automatic logic wr_to(input logic [7:0] ofs);
		wr_to = wr_fire && (aw_addr == ofs);
	endfunction

	logic rd_pos;
	logic rd_counter;
	assign rd_pos = rd_fire && (s_axi_araddr_in == OFS_POS_UPPER ||
		s_axi_araddr_in == OFS_POS_LOWER);
	assign rd_counter = rd_pos || (rd_fire && (s_axi_araddr_in == OFS_DELTA ||
		s_axi_araddr_in == OFS_REVS));

	// ----------------------------------------------------------------
	// input synchroniser and glitch filter
	// ----------------------------------------------------------------
	encoder_pins_s pin_meta;
	encoder_pins_s pin_sync;
	logic [3:0] raw;
	logic [3:0] filt;
	logic [15:0] filter_interval;
	logic [7:0] ivl_cnt;
	logic sample_tick;
	logic bypass;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= encoder_in;
			pin_sync <= pin_meta;
		end
	end

	assign raw = pin_sync;
	assign bypass = (filter_interval[7:0] == 8'h00);
	assign sample_tick = ~bypass && (ivl_cnt >= filter_interval[7:0]);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ivl_cnt <= 8'h00;
		end else if (bypass || sample_tick) begin
			ivl_cnt <= 8'h00;
		end else begin
			ivl_cnt <= ivl_cnt + 8'h01;
		end
	end

	generate
		for (genvar i = 0; i < 4; i++) begin : g_filter
			logic [FILTER_SAMPLES-1:0] taps;
			logic q;
			int ones;
			always_comb begin
				ones = 0;
				for (int k = 0; k < FILTER_SAMPLES; k++) begin
					ones = ones + int'(taps[k]);
				end
			end
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					taps <= '0;
					q <= 1'b0;
				end else begin
					// track the pin while bypassed so enabling the filter makes no false edge
					if (bypass) begin
						taps <= {FILTER_SAMPLES{raw[i]}};
					end else if (sample_tick) begin
						taps <= {taps[FILTER_SAMPLES-2:0], raw[i]};
					end
					if (bypass) begin
						q <= raw[i];
					end else if (ones >= FILTER_MAJORITY) begin
						q <= 1'b1;
					end else if (ones <= FILTER_SAMPLES - FILTER_MAJORITY) begin
						q <= 1'b0;
					end
				end
			end
			assign filt[i] = q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// edge detect and count direction
	// ----------------------------------------------------------------
	decoder_control_s ctrl;
	decoder_control_s next_ctrl;
	logic [3:0] prev;
	logic cnt_ev;
	logic cnt_up;
	logic idx_edge;
	logic home_edge;
	logic init_load;
	logic soft_init;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev <= 4'h0;
		end else begin
			prev <= filt;
		end
	end

	always_comb begin
		if (ctrl.single_phase_count) begin
			cnt_ev = filt[3] & ~prev[3];
			cnt_up = (filt[2] == ctrl.reverse_count);
		end else begin
			cnt_ev = (filt[3] ^ prev[3]) ^ (filt[2] ^ prev[2]);
			cnt_up = ~(prev[3] ^ filt[2]) ^ ctrl.reverse_count;
		end
	end

	assign idx_edge = edge_sel(prev[1], filt[1], ctrl.idx_falling_select);
	assign home_edge = edge_sel(prev[0], filt[0], ctrl.home_falling_select);
	assign soft_init = wr_to(OFS_CTRL) && w_mask[SOFT_INIT_BIT] && w_data[SOFT_INIT_BIT];
	assign init_load = soft_init
		|| (ctrl.idx_init_enable && idx_edge)
		|| (ctrl.home_init_enable && home_edge);

	// ----------------------------------------------------------------
	// counters and hold registers
	// ----------------------------------------------------------------
	logic [31:0] position;
	logic [15:0] delta;
	logic [15:0] revs;
	logic [31:0] pos_hold;
	logic [15:0] delta_hold;
	logic [15:0] revs_hold;
	logic [15:0] init_upper;
	logic [15:0] init_lower;
	logic [15:0] motion_timeout;
	logic last_up;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			position <= 32'h00000000;
		end else if (init_load) begin
			position <= {init_upper, init_lower};
		end else if (wr_to(OFS_POS_UPPER)) begin
			position[31:16] <= merge(position[31:16]);
		end else if (wr_to(OFS_POS_LOWER)) begin
			position[15:0] <= merge(position[15:0]);
		end else if (cnt_ev) begin
			position <= cnt_up ? position + 32'h1 : position - 32'h1;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			delta <= 16'h0000;
		end else if (wr_to(OFS_DELTA)) begin
			delta <= merge(delta);
		end else if (rd_pos) begin
			delta <= 16'h0000;
		end else if (cnt_ev) begin
			delta <= cnt_up ? delta + 16'h1 : delta - 16'h1;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			revs <= 16'h0000;
			last_up <= 1'b1;
		end else begin
			if (cnt_ev) begin
				last_up <= cnt_up;
			end
			if (wr_to(OFS_REVS)) begin
				revs <= merge(revs);
			end else if (idx_edge) begin
				revs <= last_up ? revs + 16'h1 : revs - 16'h1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pos_hold <= 32'h00000000;
			delta_hold <= 16'h0000;
			revs_hold <= 16'h0000;
		end else if (rd_counter) begin
			pos_hold <= position;
			delta_hold <= delta;
			revs_hold <= revs;
		end else begin
			if (wr_to(OFS_HOLD_UPPER)) pos_hold[31:16] <= merge(pos_hold[31:16]);
			if (wr_to(OFS_HOLD_LOWER)) pos_hold[15:0] <= merge(pos_hold[15:0]);
			if (wr_to(OFS_DELTA_HOLD)) delta_hold <= merge(delta_hold);
			if (wr_to(OFS_REVS_HOLD)) revs_hold <= merge(revs_hold);
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			init_upper <= REG_RESET;
			init_lower <= REG_RESET;
			filter_interval <= REG_RESET;
			motion_timeout <= TIMEOUT_RESET;
		end else begin
			if (wr_to(OFS_INIT_UPPER)) init_upper <= merge(init_upper);
			if (wr_to(OFS_INIT_LOWER)) init_lower <= merge(init_lower);
			if (wr_to(OFS_FILTER)) filter_interval <= merge(filter_interval);
			if (wr_to(OFS_TIMEOUT)) motion_timeout <= merge(motion_timeout);
		end
	end

	// ----------------------------------------------------------------
	// motion watchdog
	// ----------------------------------------------------------------
	logic [15:0] wd_timer;
	logic wd_seen;
	logic wd_restart;
	logic wd_expire;

	assign wd_restart = cnt_ev && wd_seen && (cnt_up == last_up);
	assign wd_expire = ctrl.motion_monitor_enable && !wd_restart &&
		(wd_timer >= motion_timeout);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wd_timer <= 16'h0000;
			wd_seen <= 1'b0;
		end else if (!ctrl.motion_monitor_enable) begin
			wd_timer <= 16'h0000;
			wd_seen <= 1'b0;
		end else begin
			if (cnt_ev) wd_seen <= 1'b1;
			if (wd_restart || wd_expire) begin
				wd_timer <= 16'h0000;
			end else begin
				wd_timer <= wd_timer + 16'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		if (wr_to(OFS_CTRL)) begin
			next_ctrl = (merge(ctrl) & CTRL_RW_MASK) |
				(ctrl & CTRL_W1C_MASK & ~(w_data & w_mask));
		end
		if (home_edge) next_ctrl.home_event_flag = 1'b1;
		if (idx_edge) next_ctrl.idx_event_flag = 1'b1;
		if (wd_expire) next_ctrl.timeout_event_flag = 1'b1;
		next_ctrl.soft_init_trigger = 1'b0;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	assign irq_out = (ctrl.home_event_flag && ctrl.home_irq_enable)
		|| (ctrl.idx_event_flag && ctrl.idx_irq_enable)
		|| (ctrl.timeout_event_flag && ctrl.timeout_irq_enable);

	// ----------------------------------------------------------------
	// timer switch matrix and read mux
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_capture_out <= 4'h0;
		end else begin
			unique case (ctrl.route_mode)
				ROUTE_RAW: timer_capture_out <= {raw[0], raw[1], raw[2], raw[3]};
				ROUTE_FILTERED: timer_capture_out <= {filt[0], filt[1], filt[2], filt[3]};
				ROUTE_SPLIT: timer_capture_out <= {filt[2], filt[2], filt[3], filt[3]};
				ROUTE_RESERVED: timer_capture_out <= 4'h0;
			endcase
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		unique case (s_axi_araddr_in)
			OFS_CTRL: rd_word[15:0] = ctrl;
			OFS_FILTER: rd_word[15:0] = filter_interval;
			OFS_TIMEOUT: rd_word[15:0] = motion_timeout;
			OFS_DELTA: rd_word[15:0] = delta;
			OFS_DELTA_HOLD: rd_word[15:0] = delta_hold;
			OFS_REVS: rd_word[15:0] = revs;
			OFS_REVS_HOLD: rd_word[15:0] = revs_hold;
			OFS_POS_UPPER: rd_word[15:0] = position[31:16];
			OFS_POS_LOWER: rd_word[15:0] = position[15:0];
			OFS_HOLD_UPPER: rd_word[15:0] = pos_hold[31:16];
			OFS_HOLD_LOWER: rd_word[15:0] = pos_hold[15:0];
			OFS_INIT_UPPER: rd_word[15:0] = init_upper;
			OFS_INIT_LOWER: rd_word[15:0] = init_lower;
			OFS_MONITOR: rd_word[15:0] = {8'h00, filt, raw};
			default: rd_word = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_soft_write;
		soft_init;
	endsequence

	sequence s_counter_read;
		rd_counter && !wr_fire;
	endsequence

	chk_soft_init_load: assert property (s_soft_write |=>
		position == {$past(init_upper), $past(init_lower)})
		else $error("soft init did not load position");
	chk_soft_reads_zero: assert property (rd_fire && s_axi_araddr_in == OFS_CTRL
		|=> s_axi_rvalid_out && !s_axi_rdata_out[SOFT_INIT_BIT])
		else $error("soft init bit read as one");
	chk_home_flag_set: assert property (home_edge |=> ctrl.home_event_flag)
		else $error("home flag not set");
	chk_idx_flag_hold: assert property (ctrl.idx_event_flag && !wr_fire
		|=> ctrl.idx_event_flag)
		else $error("index flag dropped");
	chk_irq_timeout: assert property ($rose(ctrl.timeout_event_flag) &&
		ctrl.timeout_irq_enable |-> irq_out)
		else $error("time-out interrupt missing");
	chk_snapshot_take: assert property (s_counter_read ##0 rd_pos |=>
		delta == 16'h0000 && delta_hold == $past(delta) && pos_hold == $past(position))
		else $error("position read snapshot wrong");
	chk_timeout_count: assert property ($rose(ctrl.timeout_event_flag) |->
		$past(wd_timer) >= $past(motion_timeout))
		else $error("watchdog expired early");
	chk_filter_bypass: assert property (bypass && $past(bypass) |->
		filt == $past(raw))
		else $error("bypass filter output wrong");
	chk_route_split: assert property (ctrl.route_mode == ROUTE_SPLIT |=>
		timer_capture_out == {$past(filt[2]), $past(filt[2]), $past(filt[3]), $past(filt[3])})
		else $error("split route wrong");
	chk_wd_disabled: assert property (!ctrl.motion_monitor_enable |=>
		wd_timer == 16'h0000)
		else $error("watchdog ran while disabled");

endmodule

// >>> testbench/quad_encoder_model.sv
`timescale 1ns/10ps
module quad_encoder_model import quad_decoder_pkg::*; (
	// clock
	input wire logic clk_in,
	// encoder pins
	output encoder_pins_s pins_out
);
	initial begin
		pins_out = '0;
	end
	// change one pin after an edge, then hold the pins for hold clocks
	task automatic set_pin(input int sel, input logic v, input int hold);
		@(posedge clk_in);
		pins_out[sel] <= v;
		repeat (hold) @(posedge clk_in);
	endtask
	// one quadrature step; forward means phase a leads phase b
	task automatic step(input logic fwd, input int hold);
		if ((pins_out.quad_input_a == pins_out.quad_input_b) == fwd) begin
			set_pin(3, ~pins_out.quad_input_a, hold);
		end else begin
			set_pin(2, ~pins_out.quad_input_b, hold);
		end
	endtask
endmodule

// >>> testbench/quad_decoder_control_tb.sv
`timescale 1ns/10ps
module quad_decoder_control_tb import quad_decoder_pkg::*;;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] cap;
	encoder_pins_s pins;
	int failures = 0;
	int total_checks = 0;

	always #25 ref_clk = ~ref_clk;

	quad_decoder_control u_quad_decoder_control (
		.ref_clk_in(ref_clk), .rst_in(rst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .encoder_in(pins),
		.timer_capture_out(cap), .irq_out(irq));

	quad_encoder_model u_quad_encoder_model (.clk_in(ref_clk), .pins_out(pins));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {16'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge ref_clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge ref_clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) begin
				bready <= 1'h0;
				chk({30'h0, r}, {30'h0, er});
				return;
			end
		end
		chk(32'h1, 32'h0);
		final_report();
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge ref_clk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ta) arvalid <= 1'h0;
			if (tr) begin
				rready <= 1'h0;
				chk(d, e);
				chk({30'h0, r}, {30'h0, er});
				return;
			end
		end
		chk(32'h1, 32'h0);
		final_report();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rc(OFS_CTRL, {16'h0, CTRL_RESET});
		rc(OFS_FILTER, 32'h0);
		rc(OFS_TIMEOUT, {16'h0, TIMEOUT_RESET});
		rc(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 16'h1234, RESP_SLVERR);
		wr(OFS_TIMEOUT, 16'h1234);
		rc(OFS_TIMEOUT, 32'h1234);
	endtask

	task automatic t_count();
		wr(OFS_INIT_UPPER, 16'h0001);
		wr(OFS_INIT_LOWER, 16'hfffe);
		wr(OFS_CTRL, 16'h0800);
		rc(OFS_CTRL, 32'h0);
		rc(OFS_POS_LOWER, 32'hfffe);
		for (int i = 0; i < 4; i++) u_quad_encoder_model.step(1'h1, i[0] ? 8 : 3);
		repeat (6) @(posedge ref_clk);
		rc(OFS_POS_UPPER, 32'h2);
		rc(OFS_DELTA_HOLD, 32'h4);
		rc(OFS_DELTA, 32'h0);
		rc(OFS_POS_LOWER, 32'h2);
		wr(OFS_HOLD_LOWER, 16'h5555);
		rc(OFS_HOLD_LOWER, 32'h5555);
		rc(OFS_POS_UPPER, 32'h2);
		rc(OFS_HOLD_LOWER, 32'h2);
	endtask

	task automatic t_dir();
		wr(OFS_CTRL, 16'h0400);
		u_quad_encoder_model.step(1'h1, 3);
		u_quad_encoder_model.step(1'h1, 6);
		rc(OFS_POS_LOWER, 32'h0);
		wr(OFS_CTRL, 16'h0a00);
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, k == 2 ? 16'h0600 : 16'h0200);
			u_quad_encoder_model.set_pin(2, k != 0, 3);
			u_quad_encoder_model.set_pin(3, 1'h0, 3);
			u_quad_encoder_model.set_pin(3, 1'h1, 6);
			rc(OFS_POS_LOWER, k == 1 ? 32'hfffe : 32'hffff);
		end
	endtask

	task automatic t_evt(input int sel, input logic [15:0] en, flag, fsel);
		wr(OFS_CTRL, en);
		u_quad_encoder_model.set_pin(sel, 1'h1, 6);
		rc(OFS_POS_LOWER, 32'hfffe);
		rc(OFS_CTRL, {16'h0, en | flag});
		chk({31'h0, irq}, 32'h1);
		wr(OFS_CTRL, flag | fsel);
		u_quad_encoder_model.step(1'h1, 6);
		u_quad_encoder_model.set_pin(sel, 1'h0, 6);
		rc(OFS_POS_LOWER, 32'hffff);
		rc(OFS_CTRL, {16'h0, flag | fsel});
		chk({31'h0, irq}, 32'h0);
		wr(OFS_CTRL, flag | fsel);
		u_quad_encoder_model.set_pin(sel, 1'h1, 6);
		rc(OFS_CTRL, {16'h0, fsel});
		wr(OFS_REVS_HOLD, 16'h0000);
		rc(OFS_REVS, 32'h2);
		rc(OFS_REVS_HOLD, 32'h2);
	endtask

	task automatic t_wdog();
		wr(OFS_TIMEOUT, 16'h0014);
		wr(OFS_CTRL, 16'h000c);
		repeat (8) @(posedge ref_clk);
		rc(OFS_CTRL, 32'h000c);
		repeat (20) @(posedge ref_clk);
		rc(OFS_CTRL, 32'h001c);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_CTRL, 16'h0004);
		rc(OFS_CTRL, 32'h0014);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_CTRL, 16'h0010);
		wr(OFS_CTRL, 16'h0004);
		for (int i = 0; i < 6; i++) u_quad_encoder_model.step(1'h1, 8);
		rc(OFS_CTRL, 32'h0004);
		wr(OFS_CTRL, 16'h0000);
		repeat (30) @(posedge ref_clk);
		rc(OFS_CTRL, 32'h0);
	endtask

	task automatic t_filter();
		wr(OFS_FILTER, 16'h0005);
		repeat (40) @(posedge ref_clk);
		u_quad_encoder_model.set_pin(0, 1'h0, 2);
		u_quad_encoder_model.set_pin(0, 1'h1, 40);
		rc(OFS_MONITOR, {24'h0, pins, pins});
		u_quad_encoder_model.set_pin(0, 1'h0, 10);
		rc(OFS_MONITOR, {24'h0, pins | 4'h1, pins});
		repeat (10) @(posedge ref_clk);
		rc(OFS_MONITOR, {24'h0, pins, pins});
	endtask

	task automatic t_route();
		logic [3:0] e;
		u_quad_encoder_model.set_pin(3, 1'h1, 4);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 16'(m));
			repeat (40) @(posedge ref_clk);
			e = {pins.home, pins.index, pins.quad_input_b, pins.quad_input_a};
			if (m == 2) e = {{2{pins.quad_input_b}}, {2{pins.quad_input_a}}};
			if (m == 3) e = 4'h0;
			chk({28'h0, cap}, {28'h0, e});
		end
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		t_reset();
		t_count();
		t_dir();
		t_evt(1, 16'h00c0, 16'h0100, 16'h0020);
		t_evt(0, 16'h6000, 16'h8000, 16'h1000);
		t_wdog();
		t_filter();
		t_route();
		final_report();
	end
endmodule
